// *** fcbg_glue.sv ***
// fcbg_glue.sv: bus glue of a floppy controller expansion card
// assumes bus strobes, card select and controller pins are all
// synchronous to ref_clk; the bus clock is ref_clk
// Behaviour
// R1 - write with A2..A0 all zero goes to the command register
// R2 - write strobe low only while access enable and pWR low
// R3 - access enable is qualified select once the wait has ended
// R4 - A0,A1 high and A2 low selects data register, read and write
// R5 - written data byte shifts out serially, clock pulse between bits
// R6 - data reads return a byte assembled serially from raw stream
// R7 - data request passes four flip-flops, one clock each
// R8 - second stage presets the qualifier gating card select
// R9 - three-megahertz jumper releases ready from the third stage
// R10 - six-megahertz jumper releases ready from the fourth stage
// R11 - write pulses stretched to 400 ns, raw read pulses to 250 ns
// R12 - completion interrupt on command done or error
// R13 - data interrupt when a byte may be moved
// R14 - both interrupts on a chosen vector line or in status port
// R15 - completion request forces qualifier high, ending any wait
// R16 - eight-inch head load output is the inverted head load
// R17 - other eight-inch inputs pass only with size select high
// R18 - eight-inch ready and two-sided inputs are inverted
// R19 - five-inch inputs pass only with size select low
// R20 - five-inch motor runs on request or hold delay
// R21 - wait enable makes the next data access drop ready
// R22 - status port selected at A2 high, A1,A0 low with card select
// R23 - bus reset also clears a pending wait
// R24 - delay stages clocked by bus clock, cleared by reset
// R25 - only one drive interface has inputs enabled
`default_nettype none
`include "fcbg_defs.svh"

module fcbg_glue
  import fcbg_pkg::*;
#(
  parameter int HALF_CELL_CYC = `FCBG_HALF_CELL_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic [2:0] addrLow,
  input  wire logic       cardSelect,
  input  wire logic       pWR_n,
  input  wire logic       pDBIN,
  input  wire fcbg_byte_t busDataIn,
  output fcbg_byte_t      busDataOut,
  output logic            busDataOe,
  output logic            busReady,
  output logic            statusPortSelect,
  output logic            cardSelectQualified,
  output logic            controllerAccessEnable_n,
  output logic            controllerWriteStrobe_n,
  output logic            controllerReadStrobe_n,
  output fcbg_byte_t      diskCommand,
  input  wire logic       waitOnDataEnable,
  input  wire logic       jumperSixMhz,
  input  wire logic       dataRequest,
  input  wire logic       commandDoneRequest,
  input  wire logic       vectorEnable,
  input  wire logic [2:0] doneVectorSelect,
  input  wire logic [2:0] dreqVectorSelect,
  output logic [7:0]      vectorIrqOut,
  output logic [7:0]      vectorIrqOe,
  input  wire logic       writeGate,
  output logic            serialWriteData,
  input  wire logic       rawReadStream,
  input  wire logic       readWindow,
  output logic            rawReadShaped,
  input  wire logic       driveSizeSelect,
  input  wire logic       headLoadA,
  output logic            headLoad8_n,
  input  wire logic       index8,
  input  wire logic       trackZero8,
  input  wire logic       writeProtect8,
  input  wire logic       ready8_n,
  input  wire logic       twoSided8_n,
  input  wire logic       index5,
  input  wire logic       trackZero5,
  input  wire logic       writeProtect5,
  input  wire logic       motorRequest,
  input  wire logic       motorHoldDelay,
  output logic            motor5,
  output logic            ctlIndex,
  output logic            ctlTrackZero,
  output logic            ctlWriteProtect,
  output logic            ctlReady,
  output logic            ctlTwoSided
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    fcbg_byte_t cmdReg;
    fcbg_byte_t dataReg;
    fcbg_byte_t readReg;
    fcbg_byte_t busData;
    logic       busOe;
    fcbg_tx_e   txState;
    fcbg_byte_t txShift;
    logic [3:0] txBits;
    logic [7:0] txTimer;
    logic       txPulse;
    fcbg_byte_t rxShift;
    logic [2:0] rxBits;
    logic       rxSeen;
    logic       rawPrev;
    logic       qualify;
    logic       waitPending;
    logic       prevCycle;
    logic       prevWrite;
  } fcbg_glue_s;

  fcbg_glue_s state;
  fcbg_glue_s next_state;

  logic qualifyPreset;
  logic readyRelease;
  logic busCycle;
  logic cycleStart;
  logic accessOn;
  logic waitStart;
  logic writeOn;
  logic rawEdge;
  fcbg_byte_t statusByte;

  function automatic logic addrIs(input logic [2:0] a,
                                  input logic [2:0] code);
    addrIs = (a == code);
  endfunction

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  fcbg_ready_delay u_delay (
    .ref_clk        (ref_clk),
    .reset          (reset),
    .dataRequest    (dataRequest),
    .useFourthStage (jumperSixMhz),
    .qualifyPreset  (qualifyPreset),
    .readyRelease   (readyRelease)
  );

  // R11 write pulse width
  fcbg_pulse_stretch #(.WIDTH_CYC(`FCBG_WRITE_PULSE_CYC)) u_wrPulse (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .trigger  (state.txPulse),
    .pulseOut (serialWriteData)
  );

  // R11 raw read pulse width
  fcbg_pulse_stretch #(.WIDTH_CYC(`FCBG_RAW_PULSE_CYC)) u_rdPulse (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .trigger  (rawEdge),
    .pulseOut (rawReadShaped)
  );

  // ---------------------------------------------------------------
  // bus decode and strobes
  // ---------------------------------------------------------------
  // R8 qualifier gates card select
  assign cardSelectQualified = cardSelect & state.qualify;
  // R3 access only once the wait is over
  // R21 a wait starting now blocks this cycle too, so no early access
  assign waitStart = waitOnDataEnable & cycleStart & ~state.waitPending &
                     addrIs(addrLow, `FCBG_ADDR_DATA) & ~readyRelease &
                     ~commandDoneRequest;
  assign accessOn = cardSelectQualified & ~state.waitPending & ~waitStart;
  assign controllerAccessEnable_n = ~accessOn;
  // R2 write strobe needs enable and pWR
  assign writeOn = accessOn & ~pWR_n;
  assign controllerWriteStrobe_n = ~writeOn;
  assign controllerReadStrobe_n =
    ~(accessOn & pDBIN & ~addrIs(addrLow, `FCBG_ADDR_STATUS));
  // R22 status port decode
  assign statusPortSelect = cardSelect &
                            addrIs(addrLow, `FCBG_ADDR_STATUS);
  assign busCycle   = cardSelect & (~pWR_n | pDBIN);
  assign cycleStart = busCycle & ~state.prevCycle;
  assign rawEdge    = rawReadStream & ~state.rawPrev;
  // R21 ready dropped while waiting
  assign busReady   = ~state.waitPending;

  // ---------------------------------------------------------------
  // interrupts and status port
  // ---------------------------------------------------------------
  // R12 R13 R14 both requests polled or vectored
  always_comb begin
    statusByte = `FCBG_BYTE_RESET;
    statusByte[`FCBG_STAT_DONE_BIT] = commandDoneRequest;
    statusByte[`FCBG_STAT_DREQ_BIT] = dataRequest;
    vectorIrqOe = 8'h00;
    if (vectorEnable) begin
      vectorIrqOe[doneVectorSelect] = commandDoneRequest;
      if (dataRequest) begin
        vectorIrqOe[dreqVectorSelect] = 1'b1;
      end
    end
  end
  // open-collector lines: only ever pulled low
  assign vectorIrqOut = 8'h00;

  // ---------------------------------------------------------------
  // drive interfaces
  // ---------------------------------------------------------------
  // R16 head load inverted
  assign headLoad8_n = ~headLoadA;
  // R20 motor held after access
  assign motor5 = motorRequest | motorHoldDelay;
  // R17 R19 R25 one buffer half enabled by size select
  assign ctlIndex        = driveSizeSelect ? index8 : index5;
  assign ctlTrackZero    = driveSizeSelect ? trackZero8 : trackZero5;
  assign ctlWriteProtect = driveSizeSelect ? writeProtect8 :
                                             writeProtect5;
  // R18 ready and two-sided inverted
  assign ctlReady    = driveSizeSelect ? ~ready8_n : 1'b1;
  assign ctlTwoSided = driveSizeSelect & ~twoSided8_n;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state           = state;
    next_state.prevCycle = busCycle;
    next_state.prevWrite = writeOn;
    next_state.rawPrev   = rawReadStream;
    next_state.txPulse   = 1'b0;

    // R1 command register write
    if (writeOn && addrIs(addrLow, `FCBG_ADDR_COMMAND)) begin
      next_state.cmdReg = busDataIn;
    end

    // read data registered onto the bus
    next_state.busOe = 1'b0;
    if (pDBIN && statusPortSelect) begin
      next_state.busData = statusByte;
      next_state.busOe   = 1'b1;
    end else if (pDBIN && accessOn &&
                 addrIs(addrLow, `FCBG_ADDR_DATA)) begin
      // R4 R6 data register read
      next_state.busData = state.readReg;
      next_state.busOe   = 1'b1;
    end

    // write serializer; a write mid-byte restarts it
    case (state.txState)
      FCBG_TX_IDLE: begin
      end
      FCBG_TX_CLOCK: begin
        if (state.txTimer == 8'h00) begin
          // R5 clock pulse between bits
          next_state.txPulse = writeGate;
          next_state.txTimer = 8'(HALF_CELL_CYC - 1);
          next_state.txState = FCBG_TX_DATA;
        end else begin
          next_state.txTimer = state.txTimer - 8'h01;
        end
      end
      FCBG_TX_DATA: begin
        if (state.txTimer == 8'h00) begin
          // R5 data bit, most significant first
          next_state.txPulse = writeGate & state.txShift[7];
          next_state.txShift = {state.txShift[6:0], 1'b0};
          next_state.txBits  = state.txBits - 4'h1;
          next_state.txTimer = 8'(HALF_CELL_CYC - 1);
          next_state.txState = (state.txBits == 4'h1) ?
                               FCBG_TX_IDLE : FCBG_TX_CLOCK;
        end else begin
          next_state.txTimer = state.txTimer - 8'h01;
        end
      end
      default: begin
        next_state.txState = FCBG_TX_IDLE;
      end
    endcase

    // R4 R5 data register write loads the serializer
    if (writeOn && !state.prevWrite &&
        addrIs(addrLow, `FCBG_ADDR_DATA)) begin
      next_state.dataReg = busDataIn;
      next_state.txShift = busDataIn;
      next_state.txBits  = 4'h8;
      next_state.txTimer = 8'h00;
      next_state.txState = FCBG_TX_CLOCK;
    end

    // R6 deserializer; a pulse in the closing cell still counts
    if (rawEdge) begin
      next_state.rxSeen = 1'b1;
    end
    if (readWindow) begin
      next_state.rxShift = {state.rxShift[6:0],
                            state.rxSeen | rawEdge};
      next_state.rxSeen  = 1'b0;
      next_state.rxBits  = state.rxBits + 3'h1;
      if (state.rxBits == 3'h7) begin
        next_state.readReg = {state.rxShift[6:0],
                              state.rxSeen | rawEdge};
      end
    end

    // R21 data access with wait enabled holds the bus
    if (waitStart) begin
      next_state.waitPending = 1'b1;
      next_state.qualify     = 1'b0;
    end
    // R8 second stage presets the qualifier
    if (qualifyPreset) begin
      next_state.qualify = 1'b1;
    end
    // R9 R10 chosen stage releases ready
    if (readyRelease) begin
      next_state.waitPending = 1'b0;
    end
    // R15 completion ends any wait
    if (commandDoneRequest) begin
      next_state.qualify     = 1'b1;
      next_state.waitPending = 1'b0;
    end
  end

  // R23 reset clears the wait, qualifier set as at power up
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state         <= '0;
      state.cmdReg  <= `FCBG_CMD_RESET;
      state.qualify <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign busDataOut  = state.busData;
  assign busDataOe   = state.busOe;
  assign diskCommand = state.cmdReg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_cmd_write;
    @(posedge ref_clk) disable iff (reset)
    !controllerWriteStrobe_n && addrLow == `FCBG_ADDR_COMMAND |=>
      diskCommand == $past(busDataIn);
  endproperty
  a_cmd_write: assert property (p_cmd_write) // R1
    else $error("command write lost");

  property p_wr_strobe;
    @(posedge ref_clk) disable iff (reset)
    !controllerWriteStrobe_n |->
      !controllerAccessEnable_n && !pWR_n;
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) // R2
    else $error("write strobe without enable");

  property p_access_en;
    @(posedge ref_clk) disable iff (reset)
    !controllerAccessEnable_n |-> cardSelectQualified && busReady;
  endproperty
  a_access_en: assert property (p_access_en) // R3
    else $error("access enabled during wait");

  property p_preset;
    @(posedge ref_clk) disable iff (reset)
    qualifyPreset |=> state.qualify;
  endproperty
  a_preset: assert property (p_preset) // R8
    else $error("qualifier not preset");

  property p_tap3;
    @(posedge ref_clk) disable iff (reset)
    !jumperSixMhz && $rose(dataRequest) ##1 dataRequest[*3] |=>
      busReady;
  endproperty
  a_tap3: assert property (p_tap3) // R9
    else $error("ready not released at third stage");

  property p_tap6;
    @(posedge ref_clk) disable iff (reset)
    jumperSixMhz && $rose(dataRequest) ##1 dataRequest[*4] |=>
      busReady;
  endproperty
  a_tap6: assert property (p_tap6) // R10
    else $error("ready not released at fourth stage");

  property p_wr_width;
    @(posedge ref_clk) disable iff (reset)
    $rose(serialWriteData) |-> serialWriteData[*8] ##32
      serialWriteData ##1 !serialWriteData;
  endproperty
  a_wr_width: assert property (p_wr_width) // R11
    else $error("write pulse width wrong");

  property p_done_clears;
    @(posedge ref_clk) disable iff (reset)
    commandDoneRequest |=> busReady && state.qualify;
  endproperty
  a_done_clears: assert property (p_done_clears) // R15
    else $error("completion did not end wait");

  property p_wait_start;
    @(posedge ref_clk) disable iff (reset)
    waitOnDataEnable && cycleStart && busReady &&
    addrLow == `FCBG_ADDR_DATA && !readyRelease &&
    !commandDoneRequest |=> !busReady;
  endproperty
  a_wait_start: assert property (p_wait_start) // R21
    else $error("data access did not wait");

  property p_reset_ready;
    @(posedge ref_clk)
    reset |=> busReady && cardSelectQualified == cardSelect;
  endproperty
  a_reset_ready: assert property (p_reset_ready) // R23
    else $error("reset left a wait pending");

  c_wait_release: cover property (@(posedge ref_clk)
    disable iff (reset) !busReady ##[1:20] busReady);
  c_cmd_write: cover property (@(posedge ref_clk)
    disable iff (reset) !controllerWriteStrobe_n);
  c_data_read: cover property (@(posedge ref_clk)
    disable iff (reset) busDataOe && !statusPortSelect);
endmodule

`default_nettype wire

// *** fcbg_defs.svh ***
// fcbg_defs.svh: constants of the floppy card bus glue
// assumes a 100 MHz ref_clk; the pulse width counts derive from its period
`ifndef FCBG_DEFS_SVH
`define FCBG_DEFS_SVH

// ---------------------------------------------------------------
// clock and pulse shaping
// ---------------------------------------------------------------
`define FCBG_CLK_PERIOD_NS   10
`define FCBG_WRITE_PULSE_NS  400
`define FCBG_RAW_PULSE_NS    250
`define FCBG_WRITE_PULSE_CYC ((`FCBG_WRITE_PULSE_NS + \
  `FCBG_CLK_PERIOD_NS - 1) / `FCBG_CLK_PERIOD_NS)
`define FCBG_RAW_PULSE_CYC   ((`FCBG_RAW_PULSE_NS + \
  `FCBG_CLK_PERIOD_NS - 1) / `FCBG_CLK_PERIOD_NS)
`define FCBG_HALF_CELL_CYC   100

// ---------------------------------------------------------------
// card-local addresses (A2..A0) and status port bits
// ---------------------------------------------------------------
`define FCBG_ADDR_COMMAND    3'h0
`define FCBG_ADDR_DATA       3'h3
`define FCBG_ADDR_STATUS     3'h4
`define FCBG_STAT_DONE_BIT   0
`define FCBG_STAT_DREQ_BIT   1

// ---------------------------------------------------------------
// reset values and delay chain taps
// ---------------------------------------------------------------
`define FCBG_CMD_RESET       8'h03
`define FCBG_BYTE_RESET      8'h00
`define FCBG_CHAIN_STAGES    4
`define FCBG_TAP_QUALIFY     1
`define FCBG_TAP_3MHZ        2
`define FCBG_TAP_6MHZ        3

`endif

// *** fcbg_pkg.sv ***
// fcbg_pkg.sv: types shared by the floppy card bus glue
// assumes fcbg_defs.svh is on the include path
`default_nettype none

package fcbg_pkg;
  typedef logic [7:0] fcbg_byte_t;

  // write serializer sequence, Gray along idle-clock-data
  typedef enum logic [1:0] {
    FCBG_TX_IDLE  = 2'h0,
    FCBG_TX_CLOCK = 2'h1,
    FCBG_TX_DATA  = 2'h3
  } fcbg_tx_e;
endpackage

`default_nettype wire

// *** fcbg_pulse_stretch.sv ***
// fcbg_pulse_stretch.sv: one-shot that stretches a trigger
// assumes the trigger is a one-cycle pulse on ref_clk
`default_nettype none

module fcbg_pulse_stretch
  import fcbg_pkg::*;
#(
  parameter int WIDTH_CYC = 40
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic trigger,
  output logic      pulseOut
);
  typedef struct packed {
    logic        active;
    logic [15:0] count;
  } fcbg_stretch_s;

  fcbg_stretch_s state;
  fcbg_stretch_s next_state;

  // retrigger reloads, so a pulse never ends short
  always_comb begin
    next_state = state;
    if (trigger) begin
      next_state.active = 1'b1;
      next_state.count  = 16'(WIDTH_CYC - 1);
    end else if (state.count != 16'h0000) begin
      next_state.count = state.count - 16'h0001;
    end else begin
      next_state.active = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign pulseOut = state.active;
endmodule

`default_nettype wire

// *** fcbg_ready_delay.sv ***
// fcbg_ready_delay.sv: four clocked stages behind the data request
// assumes dataRequest is synchronous to ref_clk
`default_nettype none
`include "fcbg_defs.svh"

module fcbg_ready_delay
  import fcbg_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic dataRequest,
  input  wire logic useFourthStage,
  output logic      qualifyPreset,
  output logic      readyRelease
);
  typedef struct packed {
    logic [`FCBG_CHAIN_STAGES-1:0] stage;
  } fcbg_delay_s;

  fcbg_delay_s state;
  fcbg_delay_s next_state;

  // R7 one clock per stage
  always_comb begin
    next_state       = state;
    next_state.stage = {state.stage[`FCBG_CHAIN_STAGES-2:0],
                        dataRequest};
  end

  // R24 history cleared by reset
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // R8 second stage presets the qualifier
  assign qualifyPreset = state.stage[`FCBG_TAP_QUALIFY];
  // R9 R10 jumper picks third or fourth stage
  assign readyRelease  = useFourthStage ?
                         state.stage[`FCBG_TAP_6MHZ] :
                         state.stage[`FCBG_TAP_3MHZ];

  property p_chain_delay;
    @(posedge ref_clk) disable iff (reset)
    $rose(dataRequest) ##1 dataRequest[*3] |=>
      state.stage[`FCBG_TAP_6MHZ];
  endproperty
  a_chain_delay: assert property (p_chain_delay) // R7
    else $error("request not through four stages");
endmodule

`default_nettype wire

// *** fcbg_cpu_model.sv ***
// fcbg_cpu_model.sv: bus master model issuing card I/O cycles
// assumes ready is looked at on ref_clk falling edges only
`default_nettype none

module fcbg_cpu_model
  import fcbg_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       busReady,
  input  wire fcbg_byte_t busDataOut,
  output logic            cardSelect,
  output logic [2:0]      addrLow,
  output logic            pWR_n,
  output logic            pDBIN,
  output fcbg_byte_t      busDataIn,
  output logic            hung
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial begin
    cardSelect = 1'b0;
    addrLow    = 3'h7;
    pWR_n      = 1'b1;
    pDBIN      = 1'b0;
    busDataIn  = 8'hA5;
    hung       = 1'b0;
  end

  // one card I/O cycle, read or write
  // a cycle spans two edges at least, then holds until ready is high
  task automatic io(input logic [2:0] a, input logic wr,
                    input fcbg_byte_t d, output fcbg_byte_t q);
    int n;
    n = 0;
    @(posedge ref_clk);
    cardSelect <= 1'b1;
    addrLow    <= a;
    pWR_n      <= ~wr;
    pDBIN      <= ~wr;
    busDataIn  <= d;
    do begin
      @(negedge ref_clk);
      n++;
    end while ((busReady !== 1'b1 || n < 2) && n < 200);
    if (n >= 200) hung <= 1'b1;
    q = busDataOut;
    @(posedge ref_clk);
    cardSelect <= 1'b0;
    pWR_n      <= 1'b1;
    pDBIN      <= 1'b0;
    busDataIn  <= ~d; // released bus keeps no stale byte
  endtask
endmodule

`default_nettype wire

// *** floppy_card_bus_glue_tb_top.sv ***
// floppy_card_bus_glue_tb_top.sv: self-checking bench of the glue
// assumes fcbg_cpu_model drives the bus side of the card
`default_nettype none
`include "fcbg_defs.svh"

`define CHK(nm, ex, got) \
  begin \
    cmpCount++; \
    if ((got) !== (ex)) begin \
      failCount++; \
      $display("unexpected %s: expected %0h seen %0h", nm, ex, got); \
    end \
  end

module floppy_card_bus_glue_tb_top
  import fcbg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        ref_clk, reset, waitOnDataEnable, jumperSixMhz, sel;
  logic        dataRequest, commandDoneRequest, writeGate;
  logic        rawReadStream, readWindow;
  logic [18:0] rv;
  wire logic       cardSelect, pWR_n, pDBIN, busDataOe, busReady, hung;
  wire logic       statusPortSelect, cardSelectQualified;
  wire logic       controllerWriteStrobe_n, serialWriteData, rawReadShaped;
  wire logic [2:0] addrLow;
  wire logic [6:0] pins;
  wire logic [7:0] vectorIrqOut, vectorIrqOe;
  wire fcbg_byte_t busDataIn, busDataOut, diskCommand;
  wire logic       probe = sel ? rawReadShaped : serialWriteData;
  int          failCount, cmpCount, k, kq, w;
  int          relExp [4] = '{5, 6, 2, 2};
  logic [2:0]  addrs [4] = '{3'h0, 3'h4, 3'h0, 3'h3};
  fcbg_byte_t  d, q, e, expCmd;

  fcbg_glue #(.HALF_CELL_CYC(45)) dut_u (
    .ref_clk, .reset, .addrLow, .cardSelect, .pWR_n, .pDBIN,
    .busDataIn, .busDataOut, .busDataOe, .busReady, .statusPortSelect,
    .cardSelectQualified, .controllerAccessEnable_n(),
    .controllerWriteStrobe_n, .controllerReadStrobe_n(), .diskCommand,
    .waitOnDataEnable, .jumperSixMhz, .dataRequest, .commandDoneRequest,
    .vectorEnable(rv[12]), .doneVectorSelect(rv[15:13]),
    .dreqVectorSelect(rv[18:16]), .vectorIrqOut, .vectorIrqOe,
    .writeGate, .serialWriteData, .rawReadStream, .readWindow,
    .rawReadShaped, .driveSizeSelect(rv[0]), .headLoadA(rv[1]),
    .headLoad8_n(pins[5]), .index8(rv[2]), .trackZero8(rv[3]),
    .writeProtect8(rv[4]), .ready8_n(rv[5]), .twoSided8_n(rv[6]),
    .index5(rv[7]), .trackZero5(rv[8]), .writeProtect5(rv[9]),
    .motorRequest(rv[10]), .motorHoldDelay(rv[11]), .motor5(pins[6]),
    .ctlIndex(pins[0]), .ctlTrackZero(pins[1]),
    .ctlWriteProtect(pins[2]), .ctlReady(pins[3]), .ctlTwoSided(pins[4])
  );

  fcbg_cpu_model cpu_u (.ref_clk, .busReady, .busDataOut, .cardSelect,
    .addrLow, .pWR_n, .pDBIN, .busDataIn, .hung);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // expected drive pins {motor, head, two, ready, wp, trk0, index}
  function automatic logic [6:0] drv_exp(input logic [18:0] v);
    return {v[10] | v[11], ~v[1], v[0] & ~v[6], v[0] ? ~v[5] : 1'b1,
            v[0] ? v[4] : v[9], v[0] ? v[3] : v[8], v[0] ? v[2] : v[7]};
  endfunction

  task automatic reportAndStop;
    if (failCount == 0 && cmpCount > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // a used-up bound is a hang: stop rather than limp on
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      failCount++;
      reportAndStop();
    end
  endtask

  // width in cycles of the next high pulse on probe
  task automatic width(output int n);
    int t;
    t = 0;
    n = 0;
    while (probe !== 1'b1 && t < 400) begin
      @(negedge ref_clk);
      t++;
    end
    bound(t, 400);
    while (probe === 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge hung) begin
    failCount++;
    reportAndStop();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {waitOnDataEnable, jumperSixMhz, sel, dataRequest} = 4'h0;
    {commandDoneRequest, writeGate, rawReadStream, readWindow} = 4'h0;
    rv = '0;
    void'($urandom(84));
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    expCmd = 8'h03;
    `CHK("cmdReset", expCmd, diskCommand);
    `CHK("readyReset", 1'b1, busReady);
    foreach (addrs[i]) begin
      d = fcbg_byte_t'($urandom);
      fork
        cpu_u.io(addrs[i], 1'b1, d, q);
        begin
          @(posedge ref_clk);
          @(negedge ref_clk);
          `CHK("wrStrobe", 1'b0, controllerWriteStrobe_n);
        end
      join
      if (addrs[i] == 3'h0) expCmd = d;
      @(negedge ref_clk);
      `CHK("cmd", expCmd, diskCommand);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk);
      commandDoneRequest <= (i == 0);
      dataRequest        <= (i == 1);
      fork
        cpu_u.io(3'h4, 1'b0, 8'h00, q);
        begin
          @(posedge ref_clk);
          @(negedge ref_clk);
          `CHK("stSel", 1'b1, statusPortSelect);
        end
      join
      `CHK("stBits", (i == 0) ? 2'h1 : 2'h2, q[1:0]);
    end
    repeat (24) begin
      @(posedge ref_clk);
      rv                 <= 19'($urandom);
      commandDoneRequest <= 1'($urandom);
      dataRequest        <= 1'($urandom);
      @(negedge ref_clk);
      e = 8'h00;
      if (rv[12] && commandDoneRequest) e[rv[15:13]] = 1'b1;
      if (rv[12] && dataRequest) e[rv[18:16]] = 1'b1;
      `CHK("pins", drv_exp(rv), pins);
      `CHK("vecOe", e, vectorIrqOe);
      `CHK("vecOut", 8'h00, vectorIrqOut);
    end
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk);
      {commandDoneRequest, dataRequest} <= 2'h0;
      jumperSixMhz     <= (m == 1);
      waitOnDataEnable <= 1'b1;
      // let the chain drain so a stale release cannot cancel the wait
      repeat (4) @(posedge ref_clk);
      fork
        cpu_u.io(3'h3, 1'b1, 8'h5A, q);
        begin
          k = 0;
          while (busReady !== 1'b0 && k < 20) begin
            @(negedge ref_clk);
            k++;
          end
          bound(k, 20);
          `CHK("wrHeld", 1'b1, controllerWriteStrobe_n);
          @(posedge ref_clk);
          waitOnDataEnable <= 1'b0;
          if (m < 2) dataRequest <= 1'b1;
          else if (m == 2) commandDoneRequest <= 1'b1;
          else reset <= 1'b1;
          k = 0;
          kq = 0;
          while (busReady !== 1'b1 && k < 20) begin
            @(negedge ref_clk);
            k++;
            if (kq == 0 && cardSelectQualified === 1'b1) kq = k;
          end
          `CHK("relCyc", relExp[m], k);
          if (m < 2) `CHK("qualCyc", 4, kq);
          @(posedge ref_clk);
          reset <= 1'b0;
        end
      join
    end
    repeat (800) @(posedge ref_clk);
    writeGate <= 1'b1;
    cpu_u.io(3'h3, 1'b1, 8'hFF, q);
    width(w);
    `CHK("wrPulse", 40, w);
    @(posedge ref_clk);
    sel           <= 1'b1;
    rawReadStream <= 1'b1;
    @(posedge ref_clk);
    rawReadStream <= 1'b0;
    width(w);
    `CHK("rawPulse", 25, w);
    // raw stream assembled, most significant first, then read back
    e = 8'h80 | fcbg_byte_t'($urandom);
    for (int b = 7; b >= 0; b--) begin
      @(posedge ref_clk);
      rawReadStream <= e[b];
      @(posedge ref_clk);
      {rawReadStream, readWindow} <= 2'h1;
      @(posedge ref_clk);
      readWindow <= 1'b0;
    end
    cpu_u.io(3'h3, 1'b0, 8'h00, q);
    `CHK("rdData", e, q);
    reportAndStop();
  end
endmodule

`default_nettype wire
